// ===== core/rcgc_clk_gate.sv
`timescale 1ns/1ps
`default_nettype none

// Latch-based gating cell: enable only changes while the clock is low
module rcgc_clk_gate (
  // Clock
  input  wire logic clk_i,
  // Enable
  input  wire logic en_i,
  // Gated clock
  output logic      gclk_o
);

  logic en_lat;

  always_latch begin
    if (!clk_i) begin
      en_lat = en_i;  // R12
    end
  end

  assign gclk_o = clk_i & en_lat;  // R12

endmodule

`default_nettype wire

// ===== core/rcgc_pkg.sv
package rcgc_pkg;

  // Register byte offsets
  localparam logic [11:0] RCGC_RUN_GATE_OFS   = 12'h104;
  localparam logic [11:0] RCGC_SLEEP_GATE_OFS = 12'h114;
  localparam logic [11:0] RCGC_DEEP_GATE_OFS  = 12'h124;
  localparam logic [11:0] RCGC_CLK_CFG_OFS    = 12'h060;
  localparam logic [11:0] RCGC_INT_STAT_OFS   = 12'h200;
  localparam logic [11:0] RCGC_INT_MASK_OFS   = 12'h204;
  localparam logic [11:0] RCGC_FAULT_ADR_OFS  = 12'h208;

  localparam logic [31:0] RCGC_SYSCTL_BASE = 32'h400F_E000;
  localparam int          RCGC_OFS_W       = 12;

  // Writable gate bits; reserved bits read as zero
  localparam logic [31:0] RCGC_GATE_MASK  = 32'h000F_5037;
  localparam logic [31:0] RCGC_GATE_RESET = 32'h0000_0000;
  localparam logic [31:0] RCGC_ZERO       = 32'h0000_0000;

  // Clock configuration: automatic gating select bit position
  localparam int          RCGC_ACG_BIT     = 27;
  localparam logic [31:0] RCGC_CFG_MASK    = 32'h0800_0000;
  localparam logic [31:0] RCGC_CFG_RESET   = 32'h0000_0000;

  // Interrupt status bits
  localparam int          RCGC_EV_FAULT    = 0;
  localparam int          RCGC_EV_GATECHG  = 1;
  localparam int          RCGC_EV_W        = 2;

  // Number of gated units and their bit positions in the gate register
  localparam int RCGC_UNITS = 11;
  localparam int RCGC_UNIT_BIT [RCGC_UNITS] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19};

  // Power modes
  typedef enum logic [2:0] {
    RCGC_MODE_RUN   = 3'b001,
    RCGC_MODE_SLEEP = 3'b010,
    RCGC_MODE_DEEP  = 3'b100
  } rcgc_mode_t;

  localparam logic [1:0] RCGC_HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] RCGC_HTRANS_SEQ    = 2'b11;
  localparam logic [2:0] RCGC_HSIZE_WORD    = 3'b010;

endpackage

// ===== core/rcgc_top.sv
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) Each gate bit enables one unit's clock
// (R2) Access to unclocked unit returns bus fault
// (R3) Reset clears run gate register
// (R4) Run, sleep, deep-sleep registers per mode
// (R5) Sleep registers used only if auto-gating set
// (R6) Bits 19..16 gate counters 3..0
// (R7) Bits 14,12 gate two-wire ports 1,0
// (R8) Bits 5,4 gate sync serial 1,0
// (R9) Bits 2..0 gate async serial 2..0
// (R10) Reserved bits read zero, writes ignored
// (R11) Gate register at offset 0x104
// (R12) Glitch-free gating cell per unit
module rcgc_top
  import rcgc_pkg::*;
#(
  parameter int UNITS = RCGC_UNITS
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  // AHB-Lite slave
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  // Power state
  input  wire logic                  sleep_i,
  input  wire logic                  deep_sleep_i,
  // Peripheral access watch: unit addressed by a bus access this cycle
  input  wire logic [UNITS-1:0]      unit_access_i,
  // Gated unit clocks, enables and access faults
  output logic      [UNITS-1:0]      unit_clk_o,
  output logic      [UNITS-1:0]      unit_en_o,
  output logic      [UNITS-1:0]      unit_fault_o,
  // Interrupt
  output logic                       irq_o
);

  typedef struct packed {
    logic [31:0]          run_gate;
    logic [31:0]          sleep_gate;
    logic [31:0]          deep_gate;
    logic [31:0]          clk_cfg;
    logic [RCGC_EV_W-1:0] int_stat;
    logic [RCGC_EV_W-1:0] int_mask;
    logic [31:0]          fault_units;
    logic                 dp_valid;
    logic                 dp_write;
    logic [RCGC_OFS_W-1:0] dp_ofs;
    logic                 dp_hit;
    logic [31:0]          rdata;
    logic                 resp;
    logic                 err2;
    logic [UNITS-1:0]     en;
  } rcgc_state_t;

  rcgc_state_t st;
  rcgc_state_t next_st;

  logic [31:0]      active_gate;
  logic [UNITS-1:0] gate_bits;
  logic             addr_ok;
  logic             take;
  logic [31:0]      wmask;

  // Select which gating register applies in the current power mode
  always_comb begin
    active_gate = st.run_gate;  // R4
    if (st.clk_cfg[RCGC_ACG_BIT]) begin  // R5
      if (deep_sleep_i) begin
        active_gate = st.deep_gate;  // R4
      end else if (sleep_i) begin
        active_gate = st.sleep_gate;  // R4
      end
    end
  end

  // Map gate bit positions onto units
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    assign gate_bits[u] = active_gate[RCGC_UNIT_BIT[u]];  // R6 R7 R8 R9

    rcgc_clk_gate u_gate (
      .clk_i  (clk_i),
      .en_i   (st.en[u]),
      .gclk_o (unit_clk_o[u])
    );  // R12

    // Fault whenever an access targets a unit whose clock is off
    assign unit_fault_o[u] = unit_access_i[u] & ~st.en[u];  // R2
  end

  assign unit_en_o = st.en;  // R1

  // Only whole-word accesses within the system control block
  assign addr_ok = (haddr_i[31:RCGC_OFS_W] == RCGC_SYSCTL_BASE[31:RCGC_OFS_W]);
  assign take    = hsel_i & hready_i & (htrans_i == RCGC_HTRANS_NONSEQ ||
                                        htrans_i == RCGC_HTRANS_SEQ);

  always_comb begin
    next_st        = st;
    next_st.en     = gate_bits;  // R1
    next_st.resp   = 1'b0;
    next_st.err2   = 1'b0;
    wmask          = RCGC_ZERO;

    // Data phase of a write
    if (st.dp_valid && st.dp_write && st.dp_hit) begin
      unique case (st.dp_ofs)
        RCGC_RUN_GATE_OFS: begin  // R11
          next_st.run_gate = hwdata_i & RCGC_GATE_MASK;  // R10
          if ((hwdata_i & RCGC_GATE_MASK) != st.run_gate) begin
            wmask[RCGC_EV_GATECHG] = 1'b1;
          end
        end
        RCGC_SLEEP_GATE_OFS: next_st.sleep_gate = hwdata_i & RCGC_GATE_MASK;  // R10
        RCGC_DEEP_GATE_OFS:  next_st.deep_gate  = hwdata_i & RCGC_GATE_MASK;  // R10
        RCGC_CLK_CFG_OFS:    next_st.clk_cfg    = hwdata_i & RCGC_CFG_MASK;
        RCGC_INT_MASK_OFS:   next_st.int_mask   = hwdata_i[RCGC_EV_W-1:0];
        default: ;
      endcase
    end

    // Sticky events: set wins over write-one-to-clear
    if (st.dp_valid && st.dp_write && st.dp_hit && st.dp_ofs == RCGC_INT_STAT_OFS) begin
      next_st.int_stat = st.int_stat & ~hwdata_i[RCGC_EV_W-1:0];
    end
    if (|unit_fault_o) begin
      wmask[RCGC_EV_FAULT] = 1'b1;  // R2
      next_st.fault_units  = RCGC_ZERO;
      for (int k = 0; k < UNITS; k++) begin
        next_st.fault_units[RCGC_UNIT_BIT[k]] = unit_fault_o[k];
      end
    end
    next_st.int_stat = next_st.int_stat | wmask[RCGC_EV_W-1:0];

    // Address phase capture
    if (hready_i) begin
      next_st.dp_valid = take;
      next_st.dp_write = hwrite_i;
      next_st.dp_ofs   = haddr_i[RCGC_OFS_W-1:0];
      next_st.dp_hit   = addr_ok && (hsize_i == RCGC_HSIZE_WORD);
      next_st.rdata    = RCGC_ZERO;
      if (take && !hwrite_i && addr_ok) begin
        unique case (haddr_i[RCGC_OFS_W-1:0])
          RCGC_RUN_GATE_OFS:   next_st.rdata = st.run_gate;  // R10 R11
          RCGC_SLEEP_GATE_OFS: next_st.rdata = st.sleep_gate;
          RCGC_DEEP_GATE_OFS:  next_st.rdata = st.deep_gate;
          RCGC_CLK_CFG_OFS:    next_st.rdata = st.clk_cfg;
          RCGC_INT_STAT_OFS:   next_st.rdata = {{(32-RCGC_EV_W){1'b0}}, st.int_stat};
          RCGC_INT_MASK_OFS:   next_st.rdata = {{(32-RCGC_EV_W){1'b0}}, st.int_mask};
          RCGC_FAULT_ADR_OFS:  next_st.rdata = st.fault_units;
          default:             next_st.rdata = RCGC_ZERO;
        endcase
      end
      // Access outside the system control block or non-word access answers ERROR in two cycles
      if (take && (!addr_ok || hsize_i != RCGC_HSIZE_WORD)) begin
        next_st.resp = 1'b1;
        next_st.dp_hit = 1'b0;
      end
    end
    if (st.resp && !st.err2) begin
      next_st.resp = 1'b1;
      next_st.err2 = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st            <= '0;
      st.run_gate   <= RCGC_GATE_RESET;  // R3
      st.sleep_gate <= RCGC_GATE_RESET;
      st.deep_gate  <= RCGC_GATE_RESET;
      st.clk_cfg    <= RCGC_CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata_o    = st.rdata;
  assign hresp_o     = st.resp;
  assign hreadyout_o = ~(st.resp & ~st.err2);
  assign irq_o       = |(st.int_stat & st.int_mask);

endmodule

`default_nettype wire

// ===== sim/rcgc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rcgc_sva
  import rcgc_pkg::*;
#(parameter int UNITS = RCGC_UNITS) (
  // Bus
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic             hsel_i,
  input wire logic [31:0]      haddr_i,
  input wire logic [1:0]       htrans_i,
  input wire logic             hwrite_i,
  input wire logic [2:0]       hsize_i,
  input wire logic [31:0]      hwdata_i,
  input wire logic             hready_i,
  input wire logic             hreadyout_o,
  input wire logic             hresp_o,
  // Units
  input wire logic             sleep_i,
  input wire logic             deep_sleep_i,
  input wire logic [UNITS-1:0] unit_access_i,
  input wire logic [UNITS-1:0] unit_clk_o,
  input wire logic [UNITS-1:0] unit_en_o,
  input wire logic [UNITS-1:0] unit_fault_o
);
  wire logic        run  = !sleep_i && !deep_sleep_i;
  wire logic        take = hsel_i && hready_i && htrans_i[1];
  wire logic        ok_a = haddr_i[31:12] == 20'h400F_E && hsize_i == RCGC_HSIZE_WORD;
  wire logic        gw   = take && ok_a && hwrite_i && haddr_i[11:0] == RCGC_RUN_GATE_OFS;
  logic [UNITS-1:0] pick;
  always_comb begin
    for (int i = 0; i < UNITS; i++) pick[i] = hwdata_i[RCGC_UNIT_BIT[i]];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_gate_wr;
    gw ##1 hreadyout_o && run;
  endsequence
  sequence s_err;
    hresp_o && !hreadyout_o ##1 hresp_o && hreadyout_o;
  endsequence
  a_reset_zero: assert property ($rose(nrst_i) |-> unit_en_o == '0 && !hresp_o)
    else $error("enables set after reset");
  a_fault_map: assert property (unit_fault_o == (unit_access_i & ~unit_en_o))
    else $error("fault map wrong");
  a_okay_ready: assert property (take && ok_a |=> hreadyout_o && !hresp_o)
    else $error("good access not okay");
  a_bad_err: assert property (take && !ok_a |=> s_err)
    else $error("bad access not refused");
  a_err_pair: assert property ($fell(hreadyout_o) |-> hresp_o ##1 hreadyout_o && hresp_o)
    else $error("error response broken");
  // Data lands one edge after the data phase, the enables one edge after that
  a_gate_write: assert property (s_gate_wr ##1 run |=> unit_en_o == $past(pick, 2))
    else $error("gate write not applied");
  a_en_cause: assert property ($changed(unit_en_o) && run && $past(run) && $past(run, 2)
    |-> $past(gw, 3))
    else $error("enable changed unasked");
  // High phase of a gated clock shows the enable latched before the edge
  a_clk_follow: assert property (@(negedge clk_i) unit_clk_o == $past(unit_en_o))
    else $error("gated clock wrong");
endmodule
bind rcgc_top rcgc_sva #(.UNITS(UNITS)) u_sva (.*);
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import rcgc_pkg::*;
;
  localparam logic [32:0] ALL = {33{1'b1}};
  localparam logic [32:0] RSP = 33'h1_0000_0000;
  logic             clk_i = 1'b0, nrst_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, dp = 1'b0;
  logic             sleep_i = 1'b0, deep_sleep_i = 1'b0;
  logic [1:0]       htrans_i = 2'h0;
  logic [2:0]       hsize_i = 3'h2;
  logic [31:0]      haddr_i = '0, hwdata_i = '0, v;
  logic [10:0]      unit_access_i = '0;
  logic [32:0]      eq[$], mq[$];
  int               err_total = 0, total_checks = 0, seed = 46;
  wire logic [31:0] hrdata_o;
  wire logic [10:0] unit_clk_o, unit_en_o, unit_fault_o;
  wire logic        hreadyout_o, hresp_o, irq_o;
  // Single slave, so its ready is the bus ready
  wire logic        hready_i = hreadyout_o;
  rcgc_top uut (.*);
  initial forever #10 clk_i = ~clk_i;
  initial begin
    #100us;
    err_total++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [10:0] pick(input logic [31:0] w);
    for (int i = 0; i < RCGC_UNITS; i++) pick[i] = w[RCGC_UNIT_BIT[i]];
  endfunction
  task automatic xfer(input logic w, input logic [11:0] o, input logic [31:0] d,
                      input logic [32:0] e, m, input logic [31:0] b = RCGC_SYSCTL_BASE,
                      input logic [2:0] sz = RCGC_HSIZE_WORD);
    @(posedge clk_i);
    eq.push_back(e);
    mq.push_back(m);
    hsel_i   <= 1'b1;
    htrans_i <= RCGC_HTRANS_NONSEQ;
    haddr_i  <= b | 32'(o);
    hwrite_i <= w;
    hsize_i  <= sz;
    do @(posedge clk_i); while (!hreadyout_o);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (!hreadyout_o);
  endtask
  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    xfer(1'b1, o, d, '0, RSP);
  endtask
  task automatic rd(input logic [11:0] o, input logic [31:0] e);
    xfer(1'b0, o, '0, {1'b0, e}, ALL);
  endtask
  task automatic look(input logic [11:0] e);
    repeat (3) @(posedge clk_i);
    chk({irq_o, unit_en_o}, e);
  endtask
  always @(posedge clk_i) begin
    if (dp && hreadyout_o) chk({hresp_o, hrdata_o} & mq.pop_front(), eq.pop_front());
    dp <= hsel_i && hready_i && htrans_i[1] ? 1'b1 : hreadyout_o ? 1'b0 : dp;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(RCGC_RUN_GATE_OFS, '0);
    repeat (4) begin
      v = $random(seed);
      wr(RCGC_RUN_GATE_OFS, v);
      rd(RCGC_RUN_GATE_OFS, v & RCGC_GATE_MASK);
      unit_access_i <= v[31:21];
      @(posedge clk_i);
      chk(unit_fault_o, unit_access_i & ~pick(v));
      chk(unit_en_o, pick(v));
    end
    xfer(1'b0, RCGC_RUN_GATE_OFS, '0, RSP, RSP, 32'h4000_0000);
    xfer(1'b1, RCGC_RUN_GATE_OFS, '0, RSP, RSP, RCGC_SYSCTL_BASE, 3'h0);
    rd(12'h300, '0);
    rd(RCGC_RUN_GATE_OFS, v & RCGC_GATE_MASK);
    unit_access_i <= '0;
    wr(RCGC_RUN_GATE_OFS, '0);
    wr(RCGC_INT_MASK_OFS, 32'h0000_0001);
    wr(RCGC_INT_STAT_OFS, 32'h0000_0003);
    rd(RCGC_INT_STAT_OFS, '0);
    unit_access_i <= 11'h001;
    @(posedge clk_i);
    unit_access_i <= '0;
    look(12'h800);
    wr(RCGC_INT_MASK_OFS, '0);
    look(12'h000);
    wr(RCGC_RUN_GATE_OFS, 32'h0000_0001);
    wr(RCGC_SLEEP_GATE_OFS, 32'h0000_0002);
    wr(RCGC_DEEP_GATE_OFS, 32'h0000_0004);
    sleep_i <= 1'b1;
    look(12'h001);
    wr(RCGC_CLK_CFG_OFS, RCGC_CFG_MASK);
    look(12'h002);
    deep_sleep_i <= 1'b1;
    look(12'h004);
    sleep_i <= 1'b0;
    deep_sleep_i <= 1'b0;
    look(12'h001);
    conclude();
  end
endmodule
`default_nettype wire
